// ==== oca_hpu_model.sv ====
// oca_hpu_model: processing unit side of the link
// assumes words are taken by the controller on the edge after they are put
`timescale 1ns/1ps
`default_nettype none
module oca_hpu_model (
	input  wire logic        core_clk,  // clock
	input  wire logic        tx_valid,  // info word valid
	input  wire logic [3:0]  tx_id,     // info identifier
	output logic             rx_valid,  // word to controller
	output logic [3:0]       rx_id,     // its identifier
	output logic [31:0]      rx_data    // its value
);
	int tx_seen [16];
	initial begin
		rx_valid = 1'b0;
		rx_id = 4'hF;
		rx_data = 32'h0;
	end
	always @(posedge core_clk) begin
		if (tx_valid === 1'b1)
			tx_seen[tx_id]++;
	end
	// one-cycle word; lines then show inverted stale values
	task automatic put(input logic [3:0] id, input logic [31:0] d);
		@(posedge core_clk);
		rx_valid <= 1'b1;
		rx_id <= id;
		rx_data <= d;
		@(posedge core_clk);
		rx_valid <= 1'b0;
		rx_id <= ~id;
		rx_data <= ~d;
	endtask
endmodule // oca_hpu_model
`default_nettype wire

// ==== oca_override_comp.sv ====
// oca_override_comp: override compensation stage with AXI4-Lite registers
// assumes link words and machine inputs synchronous to core_clk
// What this block does
// - machine information is sent only with link enabled and its id registered
// - compensation accepted only with link enabled, output enabled, id registered
// - sends status, mode, tool, modal, feedrate, overrides and compensation states
// - accepts cutting, rapid, spindle, machine error and free-form values
// - operator cutting override scales first, compensation scales the result
// - combined cutting override clamped to limit; status set while scaling
// - cutting compensation needs cycle start, link and value; else 100%
// - cutting compensation clamped into 0% to 300%
// - operator rapid override scales first, compensation scales the result
// - combined rapid override clamped to limit; status set while scaling
// - no rapid compensation on non-interpolated motion or selected positioning
// - rapid compensation needs cycle start, link, value, interpolation; else 100%
// - rapid compensation clamped into 0% to 100%
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module oca_override_comp
(
	input  wire logic        core_clk,       // 125 MHz clock
	input  wire logic        resetn,         // async reset, active low
	input  wire logic [7:0]  s_axi_awaddr,   // write address
	input  wire logic        s_axi_awvalid,  // write address valid
	output logic             s_axi_awready,  // write address ready
	input  wire logic [31:0] s_axi_wdata,    // write data
	input  wire logic [3:0]  s_axi_wstrb,    // write byte enables
	input  wire logic        s_axi_wvalid,   // write data valid
	output logic             s_axi_wready,   // write data ready
	output logic [1:0]       s_axi_bresp,    // write response
	output logic             s_axi_bvalid,   // write response valid
	input  wire logic        s_axi_bready,   // write response ready
	input  wire logic [7:0]  s_axi_araddr,   // read address
	input  wire logic        s_axi_arvalid,  // read address valid
	output logic             s_axi_arready,  // read address ready
	output logic [31:0]      s_axi_rdata,    // read data
	output logic [1:0]       s_axi_rresp,    // read response
	output logic             s_axi_rvalid,   // read data valid
	input  wire logic        s_axi_rready,   // read data ready
	input  wire logic        cycle_start,    // automatic cycle running
	input  wire logic        link_active,    // optical link communicating
	input  wire logic        rapid_pos_cmd,  // rapid positioning command
	input  wire logic        non_interp_cmd, // non-interpolated motion
	input  wire logic [7:0]  op_status,      // operation status
	input  wire logic [7:0]  op_mode,        // operation mode
	input  wire logic [7:0]  tool_type,      // tool type
	input  wire logic [7:0]  tool_edges,     // number of tool edges
	input  wire logic [15:0] modal_info,     // modal information
	input  wire logic [31:0] feedrate,       // feedrate
	input  wire logic [15:0] cut_ovr1,       // 1st operator cutting override %
	input  wire logic [15:0] cut_ovr2,       // 2nd operator cutting override %
	input  wire logic [15:0] rapid_ovr,      // operator rapid override %
	input  wire logic [15:0] spindle_ovr,    // spindle override %
	input  wire logic        rx_valid,       // word from processing unit
	input  wire logic [3:0]  rx_id,          // its data identifier
	input  wire logic [31:0] rx_data,        // its value
	output logic             tx_valid,       // information word valid
	output logic [3:0]       tx_id,          // information identifier
	output logic [31:0]      tx_data,        // information value
	output logic [15:0]      eff_cut_ovr,    // effective cutting override %
	output logic [15:0]      eff_rapid_ovr,  // effective rapid override %
	output logic             cut_comp_stat,  // cutting scaling in effect
	output logic             rapid_comp_stat // rapid scaling in effect
);
	import oca_pkg::*;
	// clamp a signed percentage into 0..max
	function automatic logic [15:0] clamp_pct(input logic [31:0] v,
			input logic [15:0] max);
		if (v[31])
			return 16'h0000;
		else if (v > {16'h0000, max})
			return max;
		else
			return v[15:0];
	endfunction
	// operator times compensation over 100, limited
	function automatic logic [15:0] scale_ovr(input logic [15:0] op,
			input logic [15:0] comp, input logic [15:0] lim);
		logic [31:0] prod;
		prod = ({16'h0000, op} * {16'h0000, comp}) / 32'd100;
		if (prod > {16'h0000, lim})
			return lim;
		else
			return prod[15:0];
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction
	logic          rst_q1_reg;
	logic          rst_n_reg;
	oca_wr_state_t wr_state_reg;
	logic [7:0]    wr_addr_reg;
	logic [31:0]   wr_data_reg;
	logic [3:0]    wr_strb_reg;
	logic          wr_fire;
	logic [2:0]    ctrl_reg;
	logic [13:0]   txid_en_reg;
	logic [5:0]    rxid_en_reg;
	logic [15:0]   cut_lim_reg;
	logic [15:0]   rapid_lim_reg;
	logic [31:0]   cut_raw_reg;
	logic [31:0]   rapid_raw_reg;
	logic [31:0]   spindle_raw_reg;
	logic [31:0]   merr_raw_reg;
	logic [31:0]   arb_lo_reg;
	logic [31:0]   arb_hi_reg;
	logic [5:0]    supplied_reg;
	logic [3:0]    tx_idx_reg;
	logic          link_on;
	logic          rx_accept;
	logic          cut_apply;
	logic          rapid_apply;
	logic          spin_apply;
	logic          merr_apply;
	logic [15:0]   cut_comp;
	logic [15:0]   rapid_comp;
	logic [31:0]   rd_mux;
	logic          rd_hit;
	logic [31:0]   info_mux;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_q1_reg <= 1'b0;
			rst_n_reg  <= 1'b0;
		end else begin
			rst_q1_reg <= 1'b1;
			rst_n_reg  <= rst_q1_reg;
		end
	end
	// write channel: address and data taken in either order
	assign wr_fire = (wr_state_reg == OCA_WR_COLLECT) && !s_axi_awready &&
		!s_axi_wready;
	always_ff @(posedge core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			wr_state_reg  <= OCA_WR_COLLECT;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= OCA_RESP_OKAY;
			wr_addr_reg   <= 8'h00;
			wr_data_reg   <= 32'h0000_0000;
			wr_strb_reg   <= 4'h0;
		end else begin
			case (wr_state_reg)
			OCA_WR_COLLECT: begin
				if (s_axi_awready && s_axi_awvalid) begin
					s_axi_awready <= 1'b0;
					wr_addr_reg   <= s_axi_awaddr;
				end
				if (s_axi_wready && s_axi_wvalid) begin
					s_axi_wready <= 1'b0;
					wr_data_reg  <= s_axi_wdata;
					wr_strb_reg  <= s_axi_wstrb;
				end
				if (wr_fire) begin
					s_axi_bvalid <= 1'b1;
					s_axi_bresp  <= (wr_addr_reg[7:2] > OCA_EFF_OFS[7:2]) ?
						OCA_RESP_SLVERR : OCA_RESP_OKAY;
					wr_state_reg <= OCA_WR_RESP;
				end
			end
			OCA_WR_RESP: begin
				if (s_axi_bready) begin
					s_axi_bvalid  <= 1'b0;
					s_axi_awready <= 1'b1;
					s_axi_wready  <= 1'b1;
					wr_state_reg  <= OCA_WR_COLLECT;
				end
			end
			default: wr_state_reg <= OCA_WR_COLLECT;
			endcase
		end
	end
	// software settings
	always_ff @(posedge core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ctrl_reg      <= OCA_CTRL_RST;
			txid_en_reg   <= OCA_TXID_RST;
			rxid_en_reg   <= OCA_RXID_RST;
			cut_lim_reg   <= OCA_CLIM_RST;
			rapid_lim_reg <= OCA_RLIM_RST;
		end else if (wr_fire) begin
			case ({wr_addr_reg[7:2], 2'b00})
			OCA_CTRL_OFS: ctrl_reg <=
				3'(merge({29'h0, ctrl_reg}, wr_data_reg, wr_strb_reg));
			OCA_TXID_OFS: txid_en_reg <=
				14'(merge({18'h0, txid_en_reg}, wr_data_reg, wr_strb_reg));
			OCA_RXID_OFS: rxid_en_reg <=
				6'(merge({26'h0, rxid_en_reg}, wr_data_reg, wr_strb_reg));
			OCA_CLIM_OFS: cut_lim_reg <=
				16'(merge({16'h0, cut_lim_reg}, wr_data_reg, wr_strb_reg));
			OCA_RLIM_OFS: rapid_lim_reg <=
				16'(merge({16'h0, rapid_lim_reg}, wr_data_reg, wr_strb_reg));
			default: ;
			endcase
		end
	end
	// link communicating means enabled and up
	assign link_on = ctrl_reg[OCA_CTRL_LINK_EN_BIT] && link_active;
	assign rx_accept = rx_valid && link_on && (rx_id <= OCA_RX_ARBHI) &&
		!ctrl_reg[OCA_CTRL_OUT_DIS_BIT] && rxid_en_reg[rx_id[2:0]];
	// received compensation values
	always_ff @(posedge core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			cut_raw_reg     <= 32'h0000_0000;
			rapid_raw_reg   <= 32'h0000_0000;
			spindle_raw_reg <= 32'h0000_0000;
			merr_raw_reg    <= 32'h0000_0000;
			arb_lo_reg      <= 32'h0000_0000;
			arb_hi_reg      <= 32'h0000_0000;
			supplied_reg    <= 6'h00;
		end else begin
			if (!link_on)
				supplied_reg <= 6'h00;
			else if (rx_accept)
				supplied_reg[rx_id[2:0]] <= 1'b1;
			if (rx_accept) begin
				case (rx_id)
				OCA_RX_CUT:     cut_raw_reg     <= rx_data;
				OCA_RX_RAPID:   rapid_raw_reg   <= rx_data;
				OCA_RX_SPINDLE: spindle_raw_reg <= rx_data;
				OCA_RX_MERR:    merr_raw_reg    <= rx_data;
				OCA_RX_ARBLO:   arb_lo_reg      <= rx_data;
				OCA_RX_ARBHI:   arb_hi_reg      <= rx_data;
				default: ;
				endcase
			end
		end
	end
	assign cut_apply = cycle_start && link_on &&
		supplied_reg[OCA_RX_CUT[2:0]];
	assign rapid_apply = cycle_start && link_on &&
		supplied_reg[OCA_RX_RAPID[2:0]] && !non_interp_cmd &&
		!(rapid_pos_cmd && ctrl_reg[OCA_CTRL_NONINTP_BIT]);
	assign spin_apply = cycle_start && link_on &&
		supplied_reg[OCA_RX_SPINDLE[2:0]];
	assign merr_apply = link_on && supplied_reg[OCA_RX_MERR[2:0]];
	assign cut_comp = cut_apply ? clamp_pct(cut_raw_reg, OCA_CUT_MAX) :
		OCA_PCT_DEFAULT;
	assign rapid_comp = rapid_apply ?
		clamp_pct(rapid_raw_reg, OCA_RAPID_MAX) : OCA_PCT_DEFAULT;
	// effective overrides, operator first then compensation
	always_ff @(posedge core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			eff_cut_ovr     <= OCA_PCT_DEFAULT;
			eff_rapid_ovr   <= OCA_PCT_DEFAULT;
			cut_comp_stat   <= 1'b0;
			rapid_comp_stat <= 1'b0;
		end else begin
			eff_cut_ovr     <= scale_ovr(cut_ovr1, cut_comp, cut_lim_reg);
			eff_rapid_ovr   <= scale_ovr(rapid_ovr, rapid_comp,
				rapid_lim_reg);
			cut_comp_stat   <= cut_apply;
			rapid_comp_stat <= rapid_apply;
		end
	end
	// machine information items by identifier
	always_comb begin
		case (tx_idx_reg)
		4'h0: info_mux = {24'h0, op_status};
		4'h1: info_mux = {24'h0, op_mode};
		4'h2: info_mux = {24'h0, tool_type};
		4'h3: info_mux = {24'h0, tool_edges};
		4'h4: info_mux = {16'h0, modal_info};
		4'h5: info_mux = feedrate;
		4'h6: info_mux = {16'h0, cut_ovr1};
		4'h7: info_mux = {16'h0, cut_ovr2};
		4'h8: info_mux = {16'h0, rapid_ovr};
		4'h9: info_mux = {16'h0, spindle_ovr};
		4'hA: info_mux = {31'h0, cut_comp_stat};
		4'hB: info_mux = {31'h0, rapid_comp_stat};
		4'hC: info_mux = {31'h0, spin_apply};
		4'hD: info_mux = {31'h0, merr_apply};
		default: info_mux = 32'h0000_0000;
		endcase
	end
	// one information item per cycle, round robin
	always_ff @(posedge core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			tx_idx_reg <= 4'h0;
			tx_valid   <= 1'b0;
			tx_id      <= 4'h0;
			tx_data    <= 32'h0000_0000;
		end else begin
			tx_idx_reg <= (tx_idx_reg == OCA_TX_LAST) ? 4'h0 : tx_idx_reg + 4'h1;
			tx_valid   <= ctrl_reg[OCA_CTRL_LINK_EN_BIT] &&
				txid_en_reg[tx_idx_reg];
			tx_id      <= tx_idx_reg;
			tx_data    <= info_mux;
		end
	end
	// read decode
	always_comb begin
		rd_hit = 1'b1;
		case ({s_axi_araddr[7:2], 2'b00})
		OCA_CTRL_OFS:  rd_mux = {29'h0, ctrl_reg};
		OCA_TXID_OFS:  rd_mux = {18'h0, txid_en_reg};
		OCA_RXID_OFS:  rd_mux = {26'h0, rxid_en_reg};
		OCA_CLIM_OFS:  rd_mux = {16'h0, cut_lim_reg};
		OCA_RLIM_OFS:  rd_mux = {16'h0, rapid_lim_reg};
		OCA_STAT_OFS:  rd_mux = {24'h0, supplied_reg, rapid_comp_stat,
			cut_comp_stat};
		OCA_CCOMP_OFS: rd_mux = {16'h0, cut_comp};
		OCA_RCOMP_OFS: rd_mux = {16'h0, rapid_comp};
		OCA_SCOMP_OFS: rd_mux = spindle_raw_reg;
		OCA_MERR_OFS:  rd_mux = merr_raw_reg;
		OCA_ARBLO_OFS: rd_mux = arb_lo_reg;
		OCA_ARBHI_OFS: rd_mux = arb_hi_reg;
		OCA_EFF_OFS:   rd_mux = {eff_rapid_ovr, eff_cut_ovr};
		default: begin
			rd_mux = 32'h0000_0000;
			rd_hit = 1'b0;
		end
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= OCA_RESP_OKAY;
		end else if (s_axi_arready && s_axi_arvalid) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux;
			s_axi_rresp   <= rd_hit ? OCA_RESP_OKAY : OCA_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule // oca_override_comp
`default_nettype wire

// ==== oca_override_comp_sva.sv ====
// oca_override_comp_sva: timing relations at the override stage ports
// assumes binding into oca_override_comp; bind lives in the testbench
`timescale 1ns/1ps
`default_nettype none
module oca_override_comp_sva (
	input wire logic        core_clk,        // clock
	input wire logic        resetn,          // reset, active low
	input wire logic        cycle_start,     // cycle running
	input wire logic        link_active,     // link communicating
	input wire logic        non_interp_cmd,  // non-interpolated motion
	input wire logic [15:0] cut_ovr1,        // operator cutting override
	input wire logic [15:0] rapid_ovr,       // operator rapid override
	input wire logic [31:0] feedrate,        // feedrate
	input wire logic        tx_valid,        // info word valid
	input wire logic [3:0]  tx_id,           // info identifier
	input wire logic [31:0] tx_data,         // info value
	input wire logic [15:0] eff_cut_ovr,     // effective cutting override
	input wire logic [15:0] eff_rapid_ovr,   // effective rapid override
	input wire logic        cut_comp_stat,   // cutting scaling
	input wire logic        rapid_comp_stat  // rapid scaling
);
	logic [2:0] up_cnt;
	logic       up;
	// skip the reset-sync cycles where outputs still show reset values
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			up_cnt <= 3'h0;
		else if (up_cnt != 3'h4)
			up_cnt <= up_cnt + 3'h1;
	end
	assign up = (up_cnt == 3'h4);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	cut_stat_cause_a: assert property (
		cut_comp_stat |-> $past(cycle_start) && $past(link_active))
		else $error("cut status without its conditions");
	cut_default_a: assert property (
		up && !$past(cycle_start)
		|-> !cut_comp_stat && eff_cut_ovr <= $past(cut_ovr1))
		else $error("cut override scaled outside a cycle");
	cut_clamp_a: assert property (
		up |-> 18'(eff_cut_ovr) <= 18'h3 * 18'($past(cut_ovr1)))
		else $error("cut override above three times operator");
	rapid_cause_a: assert property (
		rapid_comp_stat
		|-> $past(cycle_start && link_active && !non_interp_cmd))
		else $error("rapid status without its conditions");
	non_interp_a: assert property (
		up && $past(non_interp_cmd) |-> !rapid_comp_stat)
		else $error("rapid scaling on non-interpolated motion");
	rapid_clamp_a: assert property (
		up |-> eff_rapid_ovr <= $past(rapid_ovr))
		else $error("rapid override above operator value");
	tx_range_a: assert property (
		tx_valid |-> tx_id <= 4'hD)
		else $error("info identifier out of range");
	tx_order_a: assert property (
		up && tx_valid && $past(tx_valid) |-> tx_id ==
		($past(tx_id) == 4'hD ? 4'h0 : $past(tx_id) + 4'h1))
		else $error("info identifiers out of order");
	tx_feed_a: assert property (
		tx_valid && tx_id == 4'h5 |-> tx_data == $past(feedrate))
		else $error("feedrate word wrong");
endmodule // oca_override_comp_sva
`default_nettype wire

// ==== oca_pkg.sv ====
// oca_pkg: constants for the override compensation stage
// assumes an AXI4-Lite master with 32-bit data and byte addresses
package oca_pkg;
	// register byte offsets
	localparam logic [7:0] OCA_CTRL_OFS     = 8'h00;
	localparam logic [7:0] OCA_TXID_OFS     = 8'h04;
	localparam logic [7:0] OCA_RXID_OFS     = 8'h08;
	localparam logic [7:0] OCA_CLIM_OFS     = 8'h0C;
	localparam logic [7:0] OCA_RLIM_OFS     = 8'h10;
	localparam logic [7:0] OCA_STAT_OFS     = 8'h14;
	localparam logic [7:0] OCA_CCOMP_OFS    = 8'h18;
	localparam logic [7:0] OCA_RCOMP_OFS    = 8'h1C;
	localparam logic [7:0] OCA_SCOMP_OFS    = 8'h20;
	localparam logic [7:0] OCA_MERR_OFS     = 8'h24;
	localparam logic [7:0] OCA_ARBLO_OFS    = 8'h28;
	localparam logic [7:0] OCA_ARBHI_OFS    = 8'h2C;
	localparam logic [7:0] OCA_EFF_OFS      = 8'h30;
	// control register fields
	localparam int OCA_CTRL_LINK_EN_BIT     = 0;
	localparam int OCA_CTRL_OUT_DIS_BIT     = 1;
	localparam int OCA_CTRL_NONINTP_BIT     = 2;
	// reset values
	localparam logic [2:0]  OCA_CTRL_RST    = 3'h2;
	localparam logic [13:0] OCA_TXID_RST    = 14'h0000;
	localparam logic [5:0]  OCA_RXID_RST    = 6'h00;
	localparam logic [15:0] OCA_CLIM_RST    = 16'h012C;
	localparam logic [15:0] OCA_RLIM_RST    = 16'h0064;
	// compensation default and limits in percent
	localparam logic [15:0] OCA_PCT_DEFAULT = 16'h0064;
	localparam logic [15:0] OCA_CUT_MAX     = 16'h012C;
	localparam logic [15:0] OCA_RAPID_MAX   = 16'h0064;
	// receive data identifiers
	localparam logic [3:0]  OCA_RX_CUT      = 4'h0;
	localparam logic [3:0]  OCA_RX_RAPID    = 4'h1;
	localparam logic [3:0]  OCA_RX_SPINDLE  = 4'h2;
	localparam logic [3:0]  OCA_RX_MERR     = 4'h3;
	localparam logic [3:0]  OCA_RX_ARBLO    = 4'h4;
	localparam logic [3:0]  OCA_RX_ARBHI    = 4'h5;
	// identifier of the last machine information item sent
	localparam logic [3:0]  OCA_TX_LAST     = 4'hD;
	localparam logic [1:0]  OCA_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  OCA_RESP_SLVERR = 2'h2;
	typedef enum logic {OCA_WR_COLLECT, OCA_WR_RESP} oca_wr_state_t;
endpackage

// ==== tb_oca_override_comp.sv ====
// tb_oca_override_comp: register, compensation and link tests
// assumes oca_hpu_model and the checker in the same folder
`timescale 1ns/1ps
`default_nettype none
module tb_oca_override_comp;
	import oca_pkg::*;
	logic        core_clk, resetn, rx_valid, tx_valid;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, tx_data, feedrate, rx_data, rd_d;
	logic [3:0]  s_axi_wstrb, rx_id, tx_id;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, cut_comp_stat, rapid_comp_stat;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r, wr_r;
	logic        cycle_start, link_active, rapid_pos_cmd, non_interp_cmd;
	logic [7:0]  op_status, op_mode, tool_type, tool_edges;
	logic [15:0] modal_info, cut_ovr1, cut_ovr2, rapid_ovr, spindle_ovr;
	logic [15:0] eff_cut_ovr, eff_rapid_ovr;
	int          error_cnt, total_checks, cyc, n;
	logic [15:0] c_op [5] = '{16'h64, 16'hC8, 16'h96, 16'h78, 16'h64};
	logic [31:0] c_cmp [5] = '{32'hFFFF_FFFB, 32'hC8, 32'h21, 32'h96, 32'h190};
	logic [15:0] c_exp [5] = '{16'h0, 16'h12C, 16'h31, 16'hB4, 16'h12C};
	logic [31:0] r_cmp [3] = '{32'hFFFF_FFFF, 32'h96, 32'h32};
	logic [15:0] r_exp [3] = '{16'h0, 16'h50, 16'h28};
	oca_override_comp dut (.*);
	oca_hpu_model hpu (.core_clk(core_clk), .tx_valid(tx_valid),
		.tx_id(tx_id), .rx_valid(rx_valid), .rx_id(rx_id), .rx_data(rx_data));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end
	task automatic chk(input string what, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		wr_r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd_d = s_axi_rdata;
		rd_r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	function automatic logic [31:0] info_exp(input logic [3:0] id);
		case (id)
		4'h0: return 32'(op_status);
		4'h1: return 32'(op_mode);
		4'h2: return 32'(tool_type);
		4'h3: return 32'(tool_edges);
		4'h4: return 32'(modal_info);
		4'h5: return feedrate;
		4'h6: return 32'(cut_ovr1);
		4'h7: return 32'(cut_ovr2);
		4'h8: return 32'(rapid_ovr);
		default: return 32'(spindle_ovr);
		endcase
	endfunction
	task automatic settle;
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	task automatic watch;
		n = 0;
		repeat (28) begin
			@(posedge core_clk);
			#1;
			if (tx_valid === 1'b1) begin
				n++;
				chk("tx id", 32'(tx_id), 32'h5);
				chk("tx data", tx_data, feedrate);
			end
		end
	endtask
	initial begin
		resetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		{cycle_start, link_active, rapid_pos_cmd, non_interp_cmd} = 4'h0;
		{op_status, op_mode, tool_type, tool_edges} = 32'h0102_0304;
		{modal_info, feedrate} = 48'h0005_0000_0BB8;
		{cut_ovr1, cut_ovr2, rapid_ovr, spindle_ovr} = 64'h64_0064_0050_0064;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd(OCA_CTRL_OFS);
		chk("ctrl", rd_d, 32'h2);
		chk("ctrl resp", 32'(rd_r), 32'h0);
		rd(OCA_CLIM_OFS);
		chk("cut limit", rd_d, 32'h12C);
		rd(OCA_RLIM_OFS);
		chk("rapid limit", rd_d, 32'h64);
		rd(8'h40);
		chk("unmapped resp", 32'(rd_r), 32'h2);
		wr(8'h40, 32'h0);
		chk("unmapped wr resp", 32'(wr_r), 32'h2);
		$display("test registers done");
		@(posedge core_clk);
		cycle_start <= 1'b1;
		link_active <= 1'b1;
		wr(OCA_CTRL_OFS, 32'h3);
		chk("wr resp", 32'(wr_r), 32'h0);
		wr(OCA_RXID_OFS, 32'h3F);
		hpu.put(4'h0, 32'h96);
		settle();
		chk("eff cut", 32'(eff_cut_ovr), 32'h64);
		wr(OCA_CTRL_OFS, 32'h1);
		wr(OCA_RXID_OFS, 32'h0);
		hpu.put(4'h0, 32'h96);
		settle();
		chk("cut stat", 32'(cut_comp_stat), 32'h0);
		wr(OCA_RXID_OFS, 32'h3F);
		$display("test refusal done");
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk);
			cut_ovr1 <= c_op[i];
			hpu.put(4'h0, c_cmp[i]);
			settle();
			chk("eff cut", 32'(eff_cut_ovr), 32'(c_exp[i]));
			chk("cut stat", 32'(cut_comp_stat), 32'h1);
		end
		rd(OCA_CCOMP_OFS);
		chk("cut comp", rd_d, 32'h12C);
		wr(OCA_CLIM_OFS, 32'h96);
		settle();
		chk("eff cut", 32'(eff_cut_ovr), 32'h96);
		@(posedge core_clk);
		cycle_start <= 1'b0;
		settle();
		chk("eff cut", 32'(eff_cut_ovr), 32'h64);
		@(posedge core_clk);
		cycle_start <= 1'b1;
		link_active <= 1'b0;
		settle();
		chk("cut stat", 32'(cut_comp_stat), 32'h0);
		@(posedge core_clk);
		link_active <= 1'b1;
		settle();
		chk("eff cut", 32'(eff_cut_ovr), 32'h64);
		$display("test cutting done");
		for (int i = 0; i < 3; i++) begin
			hpu.put(4'h1, r_cmp[i]);
			settle();
			chk("eff rapid", 32'(eff_rapid_ovr), 32'(r_exp[i]));
			chk("rapid stat", 32'(rapid_comp_stat), 32'h1);
		end
		@(posedge core_clk);
		non_interp_cmd <= 1'b1;
		settle();
		chk("rapid stat", 32'(rapid_comp_stat), 32'h0);
		@(posedge core_clk);
		non_interp_cmd <= 1'b0;
		rapid_pos_cmd <= 1'b1;
		settle();
		chk("eff rapid", 32'(eff_rapid_ovr), 32'h28);
		wr(OCA_CTRL_OFS, 32'h5);
		settle();
		chk("eff rapid", 32'(eff_rapid_ovr), 32'h50);
		wr(OCA_RLIM_OFS, 32'h1E);
		wr(OCA_CTRL_OFS, 32'h1);
		settle();
		chk("eff rapid", 32'(eff_rapid_ovr), 32'h1E);
		$display("test rapid done");
		wr(OCA_TXID_OFS, 32'h3FFF);
		for (int i = 0; i < 20; i++) begin
			@(posedge core_clk);
			#1;
			if (tx_valid === 1'b1 && tx_id <= 4'h9)
				chk("tx item data", tx_data, info_exp(tx_id));
		end
		for (int i = 0; i < 14; i++)
			chk("tx item", 32'(hpu.tx_seen[i] != 0), 32'h1);
		wr(OCA_TXID_OFS, 32'h20);
		watch();
		chk("tx count", 32'(n), 32'h2);
		wr(OCA_CTRL_OFS, 32'h0);
		watch();
		chk("tx count", 32'(n), 32'h0);
		$display("test link send done");
		summarize();
	end
endmodule // tb_oca_override_comp
bind oca_override_comp oca_override_comp_sva chk_i (.*);
`default_nettype wire
